//--- mcps_edge_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser plus rising-edge pulse on the synchronised copy
module mcps_edge_sync (
   input  wire logic clk_sys,   // system clock
   input  wire logic rst_n,     // synchronised reset
   input  wire logic din,       // asynchronous level
   output logic      level_q,   // synchronised level
   output logic      rise_q     // one-cycle pulse on rising edge
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic rise;
   } mcps_sync_s;
   mcps_sync_s st_q, st_d;

   // s1 is read only by s2
   always_comb begin
      st_d      = st_q;
      st_d.s1   = din;
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      st_d.rise = st_q.s2 & ~st_q.s3;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level_q = st_q.s3;
   assign rise_q  = st_q.rise;
endmodule

//--- mcps_ext_clk_src.sv
`timescale 1ns/10ps
// far side of the clock pins: external main clock and external subsystem clock
module mcps_ext_clk_src #(
   parameter int HALF_NS = 30  // 16.7 MHz main clock, inside the upper range
) (
   input  wire logic run,      // source enabled
   output logic      clk_out,  // external main clock
   output logic      sub_out   // external subsystem clock
);
   // both clocks stand low while disabled so no stale edge leaks in
   initial begin
      int k;
      k = 0;
      clk_out = 1'b0;
      sub_out = 1'b0;
      forever begin
         #(HALF_NS);
         clk_out = run ? ~clk_out : 1'b0;
         k = (k + 1) % 8;
         if (k == 0) begin
            sub_out = run ? ~sub_out : 1'b0;
         end
      end
   end
endmodule

//--- mcps_pkg.sv
package mcps_pkg;
   // register byte addresses (printed offset, not a multiple of four -> index*4)
   localparam logic [15:0] MCPS_IDX_PIN_MODE   = 16'hff9f;
   localparam logic [17:0] MCPS_ADDR_PIN_MODE  = {MCPS_IDX_PIN_MODE, 2'b00};
   localparam logic [17:0] MCPS_ADDR_MAIN_MODE = 18'h00100;
   localparam logic [17:0] MCPS_ADDR_MAIN_OSC  = 18'h00104;
   localparam logic [17:0] MCPS_ADDR_PROC_CLK  = 18'h00108;
   localparam logic [17:0] MCPS_ADDR_STATUS    = 18'h0010c;
   localparam logic [17:0] MCPS_ADDR_PROC_CMD  = 18'h00110;
   // pin mode select fields
   localparam int MCPS_B_MAIN_EXT  = 7;
   localparam int MCPS_B_MAIN_OSC  = 6;
   localparam int MCPS_B_SUB_EXT   = 5;
   localparam int MCPS_B_SUB_OSC   = 4;
   localparam int MCPS_B_FREQ_RNG  = 0;
   localparam logic [7:0] MCPS_PIN_MODE_MASK = 8'hf1;
   localparam logic [7:0] MCPS_PIN_MODE_RST  = 8'h00;
   // main clock mode / main osc control / processor clock control fields
   localparam int MCPS_B_HS_SRC    = 2;
   localparam int MCPS_B_MAIN_SRC  = 0;
   localparam int MCPS_B_MOSC_STOP = 7;
   localparam int MCPS_B_SUB_START = 6;
   localparam int MCPS_B_CPU_SRC   = 4;
   localparam logic [7:0] MCPS_MAIN_MODE_MASK = 8'h05;
   localparam logic [7:0] MCPS_PROC_CLK_MASK  = 8'h50;
   localparam logic [7:0] MCPS_MAIN_OSC_RST   = 8'h80;
   // status / command bits
   localparam int MCPS_B_STALL     = 0;
   localparam int MCPS_B_LOCKED    = 1;
   localparam int MCPS_B_CMD_STOP  = 0;
   localparam int MCPS_B_CMD_WAKE  = 1;
   // timing
   localparam int  MCPS_CLK_MHZ         = 100;
   localparam real MCPS_STALL_MIN_US    = 4.06;
   localparam real MCPS_STALL_MAX_US    = 16.12;
   localparam int  MCPS_STALL_MIN_CYC   = 406;   // 4.06 us * 100 MHz, rounded up
   localparam int  MCPS_STALL_MAX_CYC   = 1612;  // 16.12 us * 100 MHz, rounded down
   localparam int  MCPS_EXT_STALL_EDGES = 160;
   localparam int  MCPS_OSC_STAB_CYC    = 2048;
   localparam int  MCPS_CNT_W           = 12;
   localparam logic [MCPS_CNT_W-1:0] MCPS_STALL_CYC = MCPS_CNT_W'(MCPS_STALL_MIN_CYC);
   localparam logic [MCPS_CNT_W-1:0] MCPS_EXT_CYC   = MCPS_CNT_W'(MCPS_EXT_STALL_EDGES);
   localparam logic [MCPS_CNT_W-1:0] MCPS_STAB_CYC  = MCPS_CNT_W'(MCPS_OSC_STAB_CYC);
   // stall sequencer states, one-hot
   typedef enum logic [3:0] {
      MCPS_ST_RUN   = 4'b0001,
      MCPS_ST_TIME  = 4'b0010,
      MCPS_ST_EXT   = 4'b0100,
      MCPS_ST_STOP  = 4'b1000
   } mcps_state_e;
endpackage

//--- mcps_tb_top.sv
`timescale 1ns/10ps
module mcps_tb_top;
   import mcps_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t mismatch", $time); end end
   localparam int EXT_HALF = 30;
   localparam int EXT_CYC  = MCPS_EXT_STALL_EDGES * 2 * EXT_HALF / 10;
   logic        clk_sys, rst_n, psel, penable, pwrite, run;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, ext_clk_pin, sub_ext_pin;
   logic        a_io, b_io, osc_en, ext_en, s_osc, s_ext, rng, hold, on_hi, on_sub;
   int          error_cnt, n_checks;

   mcps_ext_clk_src #(.HALF_NS(EXT_HALF)) u_src (.run(run), .clk_out(ext_clk_pin), .sub_out(sub_ext_pin));
   mcps_top u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clk_pin(ext_clk_pin), .sub_ext_pin(sub_ext_pin), .main_pin_a_io(a_io),
      .main_pin_b_io(b_io), .main_osc_en(osc_en), .main_ext_en(ext_en), .sub_osc_en(s_osc),
      .sub_ext_en(s_ext), .freq_range_sel(rng), .cpu_clk_hold(hold), .cpu_on_high(on_hi),
      .cpu_on_sub(on_sub));

   // free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         $display("[ERR] %0t no ready from slave", $time);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input logic [17:0] a, input logic [7:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 8'h00, r, e);
      `CHK({e, r}, {1'b0, 24'h0, x})
   endtask

   // cycles the cpu clock hold stays high, counted from when it is first seen high
   task automatic hold_len(output int c);
      int w;
      w = 0;
      c = 0;
      while (hold !== 1'b1 && w < 8) begin
         @(posedge clk_sys);
         w++;
      end
      while (hold === 1'b1 && c < 5000) begin
         @(posedge clk_sys);
         c++;
      end
   endtask

   // enter stop, check the hold, wake and measure the hold-off
   task automatic stop_wake(input int x, input int tol);
      int c;
      wr(MCPS_ADDR_PROC_CMD, 8'h01);
      repeat (3) @(posedge clk_sys);
      `CHK(hold, 1'b1)
      wr(MCPS_ADDR_PROC_CMD, 8'h02);
      hold_len(c);
      `CHK(c >= x - tol && c <= x + tol, 1'b1)
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask

   // reset values, unused bits, unmapped access
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      `CHK({a_io, b_io, rng, hold}, 4'b1100)
      rd_chk(MCPS_ADDR_PIN_MODE, MCPS_PIN_MODE_RST);
      rd_chk(MCPS_ADDR_MAIN_OSC, 8'h80);
      wr(MCPS_ADDR_PIN_MODE, 8'hfe);
      rd_chk(MCPS_ADDR_PIN_MODE, 8'hf0);
      apb(1'b1, 18'h00200, 8'h55, r, e);
      `CHK(e, 1'b1)
      apb(1'b0, 18'h00200, 8'h00, r, e);
      `CHK({e, r}, {1'b1, 32'h0})
   endtask

   // every main pin pair code, pins switched only while stopped
   task automatic t_decode();
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wr(MCPS_ADDR_PIN_MODE, {m, 6'h00});
         rd_chk(MCPS_ADDR_PIN_MODE, {m, 6'h00});
         wr(MCPS_ADDR_MAIN_OSC, 8'h00);
         repeat (2) @(posedge clk_sys);
         `CHK({a_io, b_io, osc_en, ext_en}, {m != 2'b01, m[0] == 1'b0, m == 2'b01, m == 2'b11})
         wr(MCPS_ADDR_MAIN_OSC, 8'h80);
      end
   endtask

   // subsystem pin modes and cpu clock select
   task automatic t_sub();
      wr(MCPS_ADDR_PIN_MODE, 8'h30);
      repeat (2) @(posedge clk_sys);
      `CHK(s_ext, 1'b1)
      wr(MCPS_ADDR_PIN_MODE, 8'h10);
      repeat (2) @(posedge clk_sys);
      `CHK({s_osc, s_ext}, 2'b10)
      wr(MCPS_ADDR_PROC_CLK, 8'h50);
      rd_chk(MCPS_ADDR_PROC_CLK, 8'h50);
      `CHK(on_sub, 1'b1)
   endtask

   // resonator: range stall, one-shot lock, stop exits
   task automatic t_res();
      int c;
      wr(MCPS_ADDR_PIN_MODE, 8'h40);
      wr(MCPS_ADDR_MAIN_OSC, 8'h00);
      wr(MCPS_ADDR_MAIN_MODE, 8'h05);
      repeat (2) @(posedge clk_sys);
      `CHK(on_hi, 1'b1)
      wr(MCPS_ADDR_PIN_MODE, 8'h41);
      hold_len(c);
      `CHK(c >= MCPS_STALL_MIN_CYC && c <= MCPS_STALL_MAX_CYC, 1'b1)
      `CHK(rng, 1'b1)
      wr(MCPS_ADDR_PIN_MODE, 8'h40);
      rd_chk(MCPS_ADDR_PIN_MODE, 8'h41);
      rd_chk(MCPS_ADDR_STATUS, 8'h02);
      stop_wake(MCPS_OSC_STAB_CYC, 6);
      wr(MCPS_ADDR_MAIN_MODE, 8'h00);
      stop_wake(MCPS_STALL_MIN_CYC, 6);
   endtask

   // external clock: stall counts source edges; lock clears on reset
   task automatic t_ext();
      int c;
      do_reset();
      rd_chk(MCPS_ADDR_STATUS, 8'h00);
      run <= 1'b1;
      wr(MCPS_ADDR_PIN_MODE, 8'hc0);
      wr(MCPS_ADDR_MAIN_OSC, 8'h00);
      wr(MCPS_ADDR_MAIN_MODE, 8'h05);
      wr(MCPS_ADDR_PIN_MODE, 8'hc1);
      hold_len(c);
      `CHK(c >= EXT_CYC - 14 && c <= EXT_CYC + 14, 1'b1)
      stop_wake(EXT_CYC, 14);
      run <= 1'b0;
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, run} = '0;
      paddr = '0;
      pwdata = '0;
      error_cnt = 0;
      n_checks = 0;
      do_reset();
      t_reset();
      t_decode();
      t_sub();
      t_res();
      t_ext();
      complete_run();
   end

   // cut a hang short well past the expected run length
   initial begin
      #600000;
      error_cnt++;
      complete_run();
   end
endmodule

//--- mcps_top.sv
// Register access over APB was decided locally.
`timescale 1ns/10ps
module mcps_top
   import mcps_pkg::*;
(
   input  wire logic        clk_sys,        // 100 MHz system clock
   input  wire logic        rst_n,          // async active-low reset
   input  wire logic        psel,           // apb select
   input  wire logic        penable,        // apb enable
   input  wire logic        pwrite,         // apb direction
   input  wire logic [17:0] paddr,          // apb byte address
   input  wire logic [31:0] pwdata,         // apb write data
   output logic      [31:0] prdata,         // apb read data
   output logic             pready,         // apb ready
   output logic             pslverr,        // apb error
   input  wire logic        ext_clk_pin,    // external main clock on second pin
   input  wire logic        sub_ext_pin,    // external subsystem clock pin
   output logic             main_pin_a_io,  // first main pin is a port
   output logic             main_pin_b_io,  // second main pin is a port
   output logic             main_osc_en,    // resonator amplifier enable
   output logic             main_ext_en,    // external clock input enable
   output logic             sub_osc_en,     // subsystem resonator enable
   output logic             sub_ext_en,     // subsystem external input enable
   output logic             freq_range_sel, // high range drive
   output logic             cpu_clk_hold,   // cpu clock withheld
   output logic             cpu_on_high,    // cpu runs on high-speed clock
   output logic             cpu_on_sub      // cpu runs on subsystem clock
);
   typedef struct packed {
      logic [7:0]  pin_mode;
      logic        range_locked;
      logic [7:0]  main_mode;
      logic        mosc_stop;
      logic [7:0]  proc_clk;
      logic        stopped;
      mcps_state_e state;
      logic [MCPS_CNT_W-1:0] cnt;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [8:0]  pin_out;
   } mcps_s;
   mcps_s st_q, st_d;
   // reset synchroniser kept outside the state struct: it runs on the raw reset
   logic [1:0] rst_sync_q;
   logic  rst_sync_n;
   logic  ext_level, ext_rise;
   logic  sub_level, sub_rise;

   // reset release through two flops; async assert only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_sync_q[1];

   // external clock pin sampled as a level, edges counted on clk_sys
   mcps_edge_sync u_ext_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_sync_n),
      .din     (ext_clk_pin),
      .level_q (ext_level),
      .rise_q  (ext_rise)
   );
   mcps_edge_sync u_sub_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_sync_n),
      .din     (sub_ext_pin),
      .level_q (sub_level),
      .rise_q  (sub_rise)
   );

   logic        wr_acc, rd_acc, setup, access;
   logic [7:0]  wbyte;
   logic        rng_new, rng_change;
   logic        resonator_mode, ext_mode;
   logic [31:0] rd_val;
   logic        rd_hit;

   always_comb begin
      setup  = psel & ~penable;
      access = psel & penable & st_q.pready;
      // writes land at the edge that completes the transfer, never earlier
      wr_acc = access & pwrite;
      rd_acc = setup & ~pwrite;
      wbyte  = pwdata[7:0];
      resonator_mode = ~st_q.pin_mode[MCPS_B_MAIN_EXT] & st_q.pin_mode[MCPS_B_MAIN_OSC];
      ext_mode       = st_q.pin_mode[MCPS_B_MAIN_EXT] & st_q.pin_mode[MCPS_B_MAIN_OSC];
      rng_new    = wbyte[MCPS_B_FREQ_RNG];
      rng_change = wr_acc && (paddr == MCPS_ADDR_PIN_MODE)
                   && (rng_new != st_q.pin_mode[MCPS_B_FREQ_RNG]);
      // read mux; bits 1..3 never stored so they read zero
      rd_hit = 1'b1;
      rd_val = '0;
      case (paddr)
         MCPS_ADDR_PIN_MODE:  rd_val[7:0] = st_q.pin_mode & MCPS_PIN_MODE_MASK;
         MCPS_ADDR_MAIN_MODE: rd_val[7:0] = st_q.main_mode;
         MCPS_ADDR_MAIN_OSC:  rd_val[MCPS_B_MOSC_STOP] = st_q.mosc_stop;
         MCPS_ADDR_PROC_CLK:  rd_val[7:0] = st_q.proc_clk;
         MCPS_ADDR_STATUS: begin
            rd_val[MCPS_B_STALL]  = (st_q.state != MCPS_ST_RUN);
            rd_val[MCPS_B_LOCKED] = st_q.range_locked;
         end
         MCPS_ADDR_PROC_CMD:  rd_val = '0;
         default:             rd_hit = 1'b0;
      endcase
   end

   // main next-state logic
   always_comb begin
      st_d          = st_q;
      // apb: answer in the access cycle that follows setup (zero wait states)
      st_d.pready  = setup;
      st_d.pslverr = setup & ~rd_hit;
      if (rd_acc) begin
         st_d.prdata = rd_val;
      end
      if (wr_acc) begin
         case (paddr)
            MCPS_ADDR_PIN_MODE: begin
               // pin bits kept apart from range bit
               st_d.pin_mode[7:4] = wbyte[7:4];
               if (rng_change && !st_q.range_locked) begin
                  st_d.pin_mode[MCPS_B_FREQ_RNG] = rng_new;
                  st_d.range_locked = 1'b1;
               end
            end
            MCPS_ADDR_MAIN_MODE: st_d.main_mode = wbyte & MCPS_MAIN_MODE_MASK;
            MCPS_ADDR_MAIN_OSC:  st_d.mosc_stop = wbyte[MCPS_B_MOSC_STOP];
            MCPS_ADDR_PROC_CLK:  st_d.proc_clk  = wbyte & MCPS_PROC_CLK_MASK;
            MCPS_ADDR_PROC_CMD: begin
               if (wbyte[MCPS_B_CMD_STOP]) begin
                  st_d.stopped = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // stall sequencer
      case (st_q.state)
         MCPS_ST_RUN: begin
            if (rng_change && !st_q.range_locked && rng_new
                && st_q.main_mode[MCPS_B_MAIN_SRC]) begin
               if (ext_mode) begin
                  st_d.state = MCPS_ST_EXT;
                  st_d.cnt   = MCPS_EXT_CYC;
               end else begin
                  st_d.state = MCPS_ST_TIME;
                  st_d.cnt   = MCPS_STALL_CYC;
               end
            end else if (wr_acc && paddr == MCPS_ADDR_PROC_CMD && wbyte[MCPS_B_CMD_STOP]) begin
               st_d.state = MCPS_ST_STOP;
            end
         end
         MCPS_ST_STOP: begin
            if (wr_acc && paddr == MCPS_ADDR_PROC_CMD && wbyte[MCPS_B_CMD_WAKE]) begin
               st_d.stopped = 1'b0;
               if (!st_q.pin_mode[MCPS_B_FREQ_RNG]) begin
                  st_d.state = MCPS_ST_RUN;
               end else if (!st_q.main_mode[MCPS_B_MAIN_SRC]) begin
                  st_d.state = MCPS_ST_TIME;
                  st_d.cnt   = MCPS_STALL_CYC;
               end else if (ext_mode) begin
                  st_d.state = MCPS_ST_EXT;
                  st_d.cnt   = MCPS_EXT_CYC;
               end else begin
                  st_d.state = MCPS_ST_TIME;
                  st_d.cnt   = MCPS_STAB_CYC;
               end
            end
         end
         MCPS_ST_TIME: begin
            st_d.cnt = st_q.cnt - 1'b1;
            if (st_q.cnt == MCPS_CNT_W'(1)) begin
               st_d.state = MCPS_ST_RUN;
            end
         end
         MCPS_ST_EXT: begin
            // counts edges of the external clock, not system cycles
            if (ext_rise) begin
               st_d.cnt = st_q.cnt - 1'b1;
               if (st_q.cnt == MCPS_CNT_W'(1)) begin
                  st_d.state = MCPS_ST_RUN;
               end
            end
         end
         default: st_d.state = MCPS_ST_RUN;
      endcase
      // pin usage outputs
      // first pin stays a port when the second takes the external clock
      st_d.pin_out[0] = ~resonator_mode;
      st_d.pin_out[1] = ~(resonator_mode | ext_mode);
      st_d.pin_out[2] = resonator_mode & ~st_q.mosc_stop;
      st_d.pin_out[3] = ext_mode & ~st_q.mosc_stop;
      st_d.pin_out[4] = st_q.proc_clk[MCPS_B_SUB_START]
                        | (~st_q.pin_mode[MCPS_B_SUB_EXT] & st_q.pin_mode[MCPS_B_SUB_OSC]);
      st_d.pin_out[5] = st_q.pin_mode[MCPS_B_SUB_EXT] & st_q.pin_mode[MCPS_B_SUB_OSC];
      st_d.pin_out[6] = st_q.pin_mode[MCPS_B_FREQ_RNG];
      st_d.pin_out[7] = (st_d.state != MCPS_ST_RUN);
      st_d.pin_out[8] = st_q.main_mode[MCPS_B_HS_SRC] & st_q.main_mode[MCPS_B_MAIN_SRC];
   end

   // every field of st_q; the reset synchroniser and the stall helper flops sit apart
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_q.pin_mode     <= MCPS_PIN_MODE_RST;
         st_q.range_locked <= 1'b0;
         st_q.main_mode    <= '0;
         st_q.mosc_stop    <= MCPS_MAIN_OSC_RST[MCPS_B_MOSC_STOP];
         st_q.proc_clk     <= '0;
         st_q.stopped      <= 1'b0;
         st_q.state        <= MCPS_ST_RUN;
         st_q.cnt          <= '0;
         st_q.prdata       <= '0;
         st_q.pready       <= 1'b0;
         st_q.pslverr      <= 1'b0;
         st_q.pin_out      <= 9'h003;
      end else begin
         st_q.pin_mode     <= st_d.pin_mode;
         st_q.range_locked <= st_d.range_locked;
         st_q.main_mode    <= st_d.main_mode;
         st_q.mosc_stop    <= st_d.mosc_stop;
         st_q.proc_clk     <= st_d.proc_clk;
         st_q.stopped      <= st_d.stopped;
         st_q.state        <= st_d.state;
         st_q.cnt          <= st_d.cnt;
         st_q.prdata       <= st_d.prdata;
         st_q.pready       <= st_d.pready;
         st_q.pslverr      <= st_d.pslverr;
         st_q.pin_out      <= st_d.pin_out;
      end
   end

   assign prdata         = st_q.prdata;
   assign pready         = st_q.pready;
   assign pslverr        = st_q.pslverr;
   assign main_pin_a_io  = st_q.pin_out[0];
   assign main_pin_b_io  = st_q.pin_out[1];
   assign main_osc_en    = st_q.pin_out[2];
   assign main_ext_en    = st_q.pin_out[3];
   assign sub_osc_en     = st_q.pin_out[4];
   assign sub_ext_en     = st_q.pin_out[5];
   assign freq_range_sel = st_q.pin_out[6];
   assign cpu_clk_hold   = st_q.pin_out[7];
   assign cpu_on_high    = st_q.pin_out[8];
   assign cpu_on_sub     = st_q.proc_clk[MCPS_B_CPU_SRC];

   // helper: cycles spent in a timed stall, and whether it is the stabilization wait
   logic [MCPS_CNT_W-1:0] hold_len_q;
   logic                  stab_wait_q;
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hold_len_q  <= '0;
         stab_wait_q <= 1'b0;
      end else begin
         if (st_q.state == MCPS_ST_TIME) begin
            hold_len_q <= hold_len_q + 1'b1;
         end else begin
            hold_len_q <= '0;
         end
         // latched on entry; the stabilization wait outlasts the timed maximum
         if (st_q.state != MCPS_ST_TIME) begin
            stab_wait_q <= (st_d.cnt == MCPS_STAB_CYC);
         end
      end
   end

   range_once_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      st_q.range_locked |=> $stable(st_q.pin_mode[MCPS_B_FREQ_RNG]))
      else $error("range bit changed after lock");
   pin_reserved_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      st_q.pin_mode[3:1] == 3'b000)
      else $error("reserved pin mode bits nonzero");
   // stall length checks; the stabilization wait is exempt from the timed maximum
   stall_max_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      !stab_wait_q |-> hold_len_q <= MCPS_CNT_W'(MCPS_STALL_MAX_CYC))
      else $error("timed stall too long");
   stall_min_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      (st_q.state == MCPS_ST_TIME && st_q.cnt == MCPS_CNT_W'(1) && !stab_wait_q)
      |-> hold_len_q == MCPS_CNT_W'(MCPS_STALL_MIN_CYC - 1))
      else $error("timed stall too short");
   stab_len_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      (st_q.state == MCPS_ST_TIME && st_q.cnt == MCPS_CNT_W'(1) && stab_wait_q)
      |-> hold_len_q == MCPS_CNT_W'(MCPS_OSC_STAB_CYC - 1))
      else $error("stabilization wait wrong length");
   stall_start_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      (rng_change && !st_q.range_locked && rng_new && st_q.main_mode[MCPS_B_MAIN_SRC]
       && !ext_mode && st_q.state == MCPS_ST_RUN) |=> cpu_clk_hold[*8])
      else $error("resonator stall not held");
   ext_stall_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      (st_q.state == MCPS_ST_EXT && !ext_rise) |=> st_q.state == MCPS_ST_EXT)
      else $error("external stall ended without edge");
   pin_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      !st_q.pin_mode[MCPS_B_MAIN_OSC] |=> main_pin_a_io && main_pin_b_io)
      else $error("pins not ports");
   hold_out_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      (st_q.state != MCPS_ST_RUN) |-> cpu_clk_hold)
      else $error("hold output low in stall");
   reset_val_a: assert property (@(posedge clk_sys)
      $rose(rst_sync_n) |-> st_q.pin_mode == MCPS_PIN_MODE_RST)
      else $error("pin mode not cleared");
   apb_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      (psel && !penable) |=> pready)
      else $error("no ready after setup");

   // checks on the pin decode, the range output, the range lock and the error response
   ext_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      ext_mode |=> main_pin_a_io && !main_pin_b_io)
      else $error("external clock pin decode wrong");
   res_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      resonator_mode |=> !main_pin_a_io && !main_pin_b_io)
      else $error("resonator pin decode wrong");
   range_out_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      freq_range_sel == $past(st_q.pin_mode[MCPS_B_FREQ_RNG]))
      else $error("range output does not follow range bit");
   lock_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      st_q.range_locked |=> st_q.range_locked)
      else $error("range lock dropped before reset");
   unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      (psel && !penable && !rd_hit) |=> pslverr)
      else $error("no error on unmapped access");

   // scenarios worth seeing at least once
   range_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) $rose(st_q.range_locked));
   ext_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) st_q.state == MCPS_ST_EXT);
   stop_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) st_q.state == MCPS_ST_STOP);
   stab_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) stab_wait_q && st_q.state == MCPS_ST_TIME);
   res_stall_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) !stab_wait_q && st_q.state == MCPS_ST_TIME);
endmodule
